// file: verilog/stream_walker_pkg.sv
// Constants, register map and helpers for the stream walker.
// Assumes a 32-bit Avalon-MM register bus and a 64-bit element read port.
`default_nettype none

package stream_walker_pkg;

  // Structure
  localparam int LEVELS = 6;
  localparam int ADDR_W = 32;
  localparam int CNT_W  = 16;
  localparam int DATA_W = 64;
  localparam int REG_W  = 32;

  // Register word indices (byte address / 4)
  localparam logic [5:0] IDX_CTRL      = 6'h00;
  localparam logic [5:0] IDX_STATUS    = 6'h01;
  localparam logic [5:0] IDX_BASE      = 6'h02;
  localparam logic [5:0] IDX_ELEM_CFG  = 6'h03;
  localparam logic [5:0] IDX_LEVEL0_ITERATION_COUNT     = 6'h04;
  localparam logic [5:0] IDX_STRIDE1   = 6'h0A;
  localparam logic [5:0] IDX_DELIVERED = 6'h0F;

  // Control fields
  localparam int CTRL_OPEN_BIT  = 0;
  localparam int CTRL_CLOSE_BIT = 1;

  // Status fields
  localparam int STAT_OPEN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;
  localparam int STAT_BUSY_BIT = 3;

  // Element configuration fields
  localparam int ELEM_SIZE_LSB   = 0;
  localparam int ELEM_CPLX_BIT   = 2;
  localparam int ELEM_FLOAT_BIT  = 3;
  localparam int ELEM_SIGNED_BIT = 4;
  localparam int ELEM_CFG_W      = 5;

  // Reset values
  localparam logic [31:0]          RST_BASE   = 32'h0000_0000;
  localparam logic [ELEM_CFG_W-1:0] RST_ELEM  = 5'h00;
  localparam logic [31:0]          RST_ICNT   = 32'h0000_0001;
  localparam logic [31:0]          RST_STRIDE = 32'h0000_0000;

  // Bytes in one element for a size code
  function automatic logic [31:0] element_size_bytes(input logic [1:0] sz);
    return 32'h0000_0001 << sz;
  endfunction

  // Element stride to signed byte offset
  function automatic logic [31:0] scale_stride(input logic [31:0] d, input logic [1:0] sz);
    logic signed [31:0] s;
    s = d;
    return s <<< sz;
  endfunction

  // Keep only the bytes of one element
  function automatic logic [DATA_W-1:0] elem_mask(input logic [1:0] sz);
    unique case (sz)
      2'h0: return 64'h0000_0000_0000_00FF;
      2'h1: return 64'h0000_0000_0000_FFFF;
      2'h2: return 64'h0000_0000_FFFF_FFFF;
      2'h3: return 64'hFFFF_FFFF_FFFF_FFFF;
    endcase
  endfunction

  // Byte-enable merge of a write
  function automatic logic [REG_W-1:0] be_merge(input logic [REG_W-1:0] old,
                                                input logic [REG_W-1:0] wd,
                                                input logic [3:0]       be);
    logic [REG_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// file: verilog/walk_if.sv
// Sequencer to loop nest walker interface.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface walk_if #(
  parameter int ADDR_W = stream_walker_pkg::ADDR_W,
  parameter int CNT_W  = stream_walker_pkg::CNT_W
);
  import stream_walker_pkg::*;

  logic              start;
  logic              step;
  logic [ADDR_W-1:0] base;
  logic [1:0]        size_log2;
  logic [CNT_W-1:0]  icnt [LEVELS];
  logic [31:0]       stride [1:LEVELS-1];
  logic [ADDR_W-1:0] addr;
  logic              last;

  modport ctl (output start, step, base, size_log2, icnt, stride, input addr, last);
  modport gen (input start, step, base, size_log2, icnt, stride, output addr, last);
endinterface

`default_nettype wire

// file: verilog/loop_nest_walker.sv
// Six-level loop nest pointer walker for forward linear streams.
// Assumes parameters stay fixed between start and the last step.
`timescale 1ns/1ps
`default_nettype none

module loop_nest_walker #(
  parameter int ADDR_W = stream_walker_pkg::ADDR_W,
  parameter int CNT_W  = stream_walker_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Walker control
  walk_if.gen       w
);
  import stream_walker_pkg::*;

  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] saved_q [1:LEVELS-1];
  logic [CNT_W-1:0]  cnt_q   [LEVELS];
  logic [LEVELS-1:0] at_end;
  logic [2:0]        lvl;
  logic [ADDR_W-1:0] next_start;

  // Lowest level not at its end advances
  always_comb begin
    lvl = 3'h0;
    for (int l = 0; l < LEVELS; l++) begin
      at_end[l] = (cnt_q[l] == CNT_W'(w.icnt[l] - 1'b1));
    end
    for (int l = LEVELS-1; l >= 0; l--) begin
      if (!at_end[l]) begin
        lvl = 3'(l);
      end
    end
    next_start = ptr_q;
    for (int l = 1; l < LEVELS; l++) begin
      if (lvl == 3'(l)) begin
        next_start = saved_q[l] + ADDR_W'(scale_stride(w.stride[l], w.size_log2));
      end
    end
  end

  assign w.last = &at_end;
  assign w.addr = ptr_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_q <= '0;
      for (int l = 0; l < LEVELS; l++) begin
        cnt_q[l] <= '0;
      end
      for (int l = 1; l < LEVELS; l++) begin
        saved_q[l] <= '0;
      end
    end else if (w.start) begin
      ptr_q <= w.base;
      for (int l = 0; l < LEVELS; l++) begin
        cnt_q[l] <= '0;
      end
      for (int l = 1; l < LEVELS; l++) begin
        saved_q[l] <= w.base;
      end
    end else if (w.step && !w.last) begin
      if (lvl == 3'h0) begin
        cnt_q[0] <= cnt_q[0] + 1'b1;
        ptr_q    <= ptr_q + ADDR_W'(element_size_bytes(w.size_log2));
      end else begin
        ptr_q <= next_start;
        for (int l = 0; l < LEVELS; l++) begin
          if (3'(l) < lvl) begin
            cnt_q[l] <= '0;
          end else if (3'(l) == lvl) begin
            cnt_q[l] <= cnt_q[l] + 1'b1;
          end
        end
        for (int l = 1; l < LEVELS; l++) begin
          if (3'(l) <= lvl) begin
            saved_q[l] <= next_start;
          end
        end
      end
    end
  end

endmodule // loop_nest_walker

`default_nettype wire

// file: verilog/stream_element_address_walker.sv
// Stream front end: register slave, fetch sequencer and element delivery.
// Assumes memory returns each element in the low bits of mem_rdata, in order.
//
// Summary of operation
// - Base, address sequence, element size, type stay fixed for the open stream.
// - Elements reach the core in walk order, repeats delivered again.
// - Every element lifetime starts when the stream opens.
// - Lifetime ends at final reference read, or at close.
// - Only an element's last reference may end its lifetime.
// - An element may be fetched anytime in its lifetime, even repeatedly.
// - Values show writes before lifetime and never writes after it.
// - Writes during lifetime may appear in any subset.
// - Incidental reads are never delivered as stream references.
// - All elements share one size and one numeric type.
// - Complex elements split into two sub-elements; element is the fetch unit.
// - Addresses depend on stream parameters only, never on fetched data.
// - Fetch may run ahead; data is dropped once handed over.
// - Fetch order equals presentation order to the core.
// - Innermost loop steps upward by one element size per fetch.
// - Six loop levels walk from the base, each with its own count.
// - Each outer level restarts from its saved pointer plus its stride.
// - Level-0 count sets contiguous elements; its stride is element size.
// - Levels one to five stride between consecutive iteration starts.
`timescale 1ns/1ps
`default_nettype none

module stream_element_address_walker #(
  parameter int ADDR_W = stream_walker_pkg::ADDR_W,
  parameter int CNT_W  = stream_walker_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              reset,
  // Avalon-MM register slave
  input  wire logic [7:0]                        avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [stream_walker_pkg::REG_W-1:0] avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [stream_walker_pkg::REG_W-1:0] avs_readdata,
  output logic                                   avs_waitrequest,
  // Memory read port
  output logic                                   mem_req,
  output logic      [ADDR_W-1:0]                 mem_addr,
  output logic      [1:0]                        mem_size,
  input  wire logic                              mem_gnt,
  input  wire logic                              mem_rvalid,
  input  wire logic [stream_walker_pkg::DATA_W-1:0] mem_rdata,
  // Element delivery to the core
  output logic                                   elem_valid,
  input  wire logic                              elem_ready,
  output logic      [stream_walker_pkg::DATA_W-1:0] elem_data,
  output logic      [stream_walker_pkg::DATA_W/2-1:0] elem_sub0,
  output logic      [stream_walker_pkg::DATA_W/2-1:0] elem_sub1,
  output logic                                   elem_complex,
  output logic                                   elem_float,
  output logic                                   elem_signed,
  output logic      [1:0]                        elem_size,
  // Stream state
  output logic                                   stream_open
);
  import stream_walker_pkg::*;

  if (ADDR_W < 8 || ADDR_W > REG_W) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end
  if (CNT_W < 1 || CNT_W > REG_W) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 32");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_ISSUE, ST_WAIT, ST_PRESENT, ST_DRAIN
  } fetch_state_e;

  // Registers
  logic [ADDR_W-1:0]     base_q;
  logic [ELEM_CFG_W-1:0] elem_cfg_q;
  logic [CNT_W-1:0]      icnt_q   [LEVELS];
  logic [REG_W-1:0]      stride_q [1:LEVELS-1];
  logic [REG_W-1:0]      delivered_q;
  logic                  open_q;
  logic                  done_q;
  logic                  err_q;

  // Bus slave state
  logic                  waitreq_q;
  logic [REG_W-1:0]      rdata_q;
  logic [REG_W-1:0]      rd_mux;
  logic [5:0]            widx;
  logic                  bus_take;
  logic                  wr_fire;
  logic                  open_cmd;
  logic                  close_cmd;
  logic                  params_ok;

  // Sequencer and outputs
  fetch_state_e               state_q;
  logic                       mem_req_q;
  logic [ADDR_W-1:0]          mem_addr_q;
  logic                       elem_valid_q;
  logic [DATA_W-1:0]          elem_data_q;
  logic [DATA_W/2-1:0]        sub0_q;
  logic [DATA_W/2-1:0]        sub1_q;
  logic                       accept;
  logic                       handoff;
  logic [DATA_W-1:0]          fetched;
  logic [1:0]                 sz;

  walk_if #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) walk ();

  loop_nest_walker #(
    .ADDR_W (ADDR_W),
    .CNT_W  (CNT_W)
  ) u_walker (
    .mclk  (mclk),
    .reset (reset),
    .w     (walk.gen)
  );

  assign sz       = elem_cfg_q[ELEM_SIZE_LSB +: 2];
  assign widx     = avs_address[7:2];
  assign bus_take = (avs_read || avs_write) && waitreq_q;
  assign wr_fire  = avs_write && !waitreq_q;

  assign open_cmd  = wr_fire && (widx == IDX_CTRL) && avs_byteenable[0] &&
                     avs_writedata[CTRL_OPEN_BIT];
  assign close_cmd = wr_fire && (widx == IDX_CTRL) && avs_byteenable[0] &&
                     avs_writedata[CTRL_CLOSE_BIT];

  // Parameters that the walker can serve
  always_comb begin
    params_ok = !(elem_cfg_q[ELEM_CPLX_BIT] && (sz == 2'h0));
    for (int l = 0; l < LEVELS; l++) begin
      if (icnt_q[l] == '0) begin
        params_ok = 1'b0;
      end
    end
  end

  assign accept  = open_cmd && !close_cmd && (state_q == ST_IDLE) && params_ok;
  assign handoff = elem_valid_q && elem_ready;

  // Walker hookup
  assign walk.start     = accept;
  assign walk.step      = handoff && (state_q == ST_PRESENT) && !close_cmd;
  assign walk.base      = base_q;
  assign walk.size_log2 = sz;
  always_comb begin
    for (int l = 0; l < LEVELS; l++) begin
      walk.icnt[l] = icnt_q[l];
    end
    for (int l = 1; l < LEVELS; l++) begin
      walk.stride[l] = stride_q[l];
    end
  end

  // One wait cycle per access
  always_ff @(posedge mclk) begin
    if (reset) begin
      waitreq_q <= 1'b1;
    end else if (bus_take) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    unique case (widx)
      IDX_CTRL: rd_mux = '0;
      IDX_STATUS: begin
        rd_mux[STAT_OPEN_BIT] = open_q;
        rd_mux[STAT_DONE_BIT] = done_q;
        rd_mux[STAT_ERR_BIT]  = err_q;
        rd_mux[STAT_BUSY_BIT] = (state_q != ST_IDLE);
      end
      IDX_BASE:      rd_mux = REG_W'(base_q);
      IDX_ELEM_CFG:  rd_mux = REG_W'(elem_cfg_q);
      IDX_DELIVERED: rd_mux = delivered_q;
      default: begin
        for (int l = 0; l < LEVELS; l++) begin
          if (widx == IDX_LEVEL0_ITERATION_COUNT + 6'(l)) begin
            rd_mux = REG_W'(icnt_q[l]);
          end
        end
        for (int l = 1; l < LEVELS; l++) begin
          if (widx == IDX_STRIDE1 + 6'(l - 1)) begin
            rd_mux = stride_q[l];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (bus_take && avs_read) begin
      rdata_q <= rd_mux;
    end
  end

  // Stream parameters, frozen while open
  always_ff @(posedge mclk) begin
    if (reset) begin
      base_q     <= ADDR_W'(RST_BASE);
      elem_cfg_q <= RST_ELEM;
      for (int l = 0; l < LEVELS; l++) begin
        icnt_q[l] <= CNT_W'(RST_ICNT);
      end
      for (int l = 1; l < LEVELS; l++) begin
        stride_q[l] <= RST_STRIDE;
      end
    end else if (wr_fire && !open_q && (state_q == ST_IDLE)) begin
      if (widx == IDX_BASE) begin
        base_q <= ADDR_W'(be_merge(REG_W'(base_q), avs_writedata, avs_byteenable));
      end
      if (widx == IDX_ELEM_CFG) begin
        elem_cfg_q <= ELEM_CFG_W'(be_merge(REG_W'(elem_cfg_q), avs_writedata,
                                           avs_byteenable));
      end
      for (int l = 0; l < LEVELS; l++) begin
        if (widx == IDX_LEVEL0_ITERATION_COUNT + 6'(l)) begin
          icnt_q[l] <= CNT_W'(be_merge(REG_W'(icnt_q[l]), avs_writedata, avs_byteenable));
        end
      end
      for (int l = 1; l < LEVELS; l++) begin
        if (widx == IDX_STRIDE1 + 6'(l - 1)) begin
          stride_q[l] <= be_merge(stride_q[l], avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // Stream open, done and error flags
  always_ff @(posedge mclk) begin
    if (reset) begin
      open_q <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      if (close_cmd) begin
        open_q <= 1'b0;
      end else if (accept) begin
        open_q <= 1'b1;
      end
      if (accept) begin
        done_q <= 1'b0;
      end else if (handoff && (state_q == ST_PRESENT) && walk.last) begin
        done_q <= 1'b1;
      end
      if (open_cmd && !close_cmd && (state_q == ST_IDLE)) begin
        err_q <= !params_ok;
      end
    end
  end

  // Delivered element count
  always_ff @(posedge mclk) begin
    if (reset) begin
      delivered_q <= '0;
    end else if (accept) begin
      delivered_q <= '0;
    end else if (handoff) begin
      delivered_q <= delivered_q + 1'b1;
    end
  end

  // Fetch sequencer: one reference in flight
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_q <= close_cmd ? ST_IDLE : ST_ISSUE;
        end
        ST_ISSUE: begin
          if (close_cmd) begin
            state_q <= mem_gnt ? ST_DRAIN : ST_IDLE;
          end else if (mem_gnt) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (close_cmd) begin
            state_q <= mem_rvalid ? ST_IDLE : ST_DRAIN;
          end else if (mem_rvalid) begin
            state_q <= ST_PRESENT;
          end
        end
        ST_PRESENT: begin
          if (close_cmd) begin
            state_q <= ST_IDLE;
          end else if (handoff) begin
            state_q <= walk.last ? ST_IDLE : ST_LOAD;
          end
        end
        ST_DRAIN: begin
          if (mem_rvalid) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Memory request
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
    end else if (state_q == ST_LOAD && !close_cmd) begin
      mem_req_q  <= 1'b1;
      mem_addr_q <= walk.addr;
    end else if (state_q == ST_ISSUE && (mem_gnt || close_cmd)) begin
      mem_req_q  <= 1'b0;
    end
  end

  assign fetched = mem_rdata & elem_mask(sz);

  // Element hand-off register
  always_ff @(posedge mclk) begin
    if (reset) begin
      elem_valid_q <= 1'b0;
      elem_data_q  <= '0;
      sub0_q       <= '0;
      sub1_q       <= '0;
    end else if (state_q == ST_WAIT && mem_rvalid && !close_cmd) begin
      elem_valid_q <= 1'b1;
      elem_data_q  <= fetched;
      if (elem_cfg_q[ELEM_CPLX_BIT]) begin
        sub0_q <= (DATA_W/2)'(fetched & elem_mask(sz - 2'h1));
        sub1_q <= (DATA_W/2)'((fetched >> (6'h08 << (sz - 2'h1))) &
                              elem_mask(sz - 2'h1));
      end else begin
        sub0_q <= '0;
        sub1_q <= '0;
      end
    end else if (handoff || close_cmd) begin
      elem_valid_q <= 1'b0;
      elem_data_q  <= '0;
      sub0_q       <= '0;
      sub1_q       <= '0;
    end
  end

  // Outputs
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign mem_req         = mem_req_q;
  assign mem_addr        = mem_addr_q;
  assign mem_size        = sz;
  assign elem_valid      = elem_valid_q;
  assign elem_data       = elem_data_q;
  assign elem_sub0       = sub0_q;
  assign elem_sub1       = sub1_q;
  assign elem_complex    = elem_cfg_q[ELEM_CPLX_BIT];
  assign elem_float      = elem_cfg_q[ELEM_FLOAT_BIT];
  assign elem_signed     = elem_cfg_q[ELEM_SIGNED_BIT];
  assign elem_size       = sz;
  assign stream_open     = open_q;

endmodule // stream_element_address_walker

`default_nettype wire

// file: sim/walker_monitor.sv
// Port checks on the walker top.
// Assumes one clock mclk and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module walker_monitor #(
  parameter int ADDR_W = 32,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input wire logic                                  mclk,
  input wire logic                                  reset,
  // Fetch port
  input wire logic                                  mem_req,
  input wire logic [ADDR_W-1:0]                     mem_addr,
  input wire logic [1:0]                            mem_size,
  input wire logic                                  mem_gnt,
  // Delivery and state
  input wire logic                                  elem_valid,
  input wire logic                                  elem_ready,
  input wire logic [stream_walker_pkg::DATA_W-1:0]   elem_data,
  input wire logic [stream_walker_pkg::DATA_W/2-1:0] elem_sub0,
  input wire logic [stream_walker_pkg::DATA_W/2-1:0] elem_sub1,
  input wire logic                                  elem_complex,
  input wire logic [1:0]                            elem_size,
  input wire logic                                  stream_open
);
  import stream_walker_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  req_hold_a: assert property (mem_req && !mem_gnt |=>
    (mem_req && $stable(mem_addr)) || !stream_open) else $error("request dropped");
  close_idle_a: assert property ($fell(stream_open) |->
    (!mem_req && !elem_valid) [*3]) else $error("activity after close");
  elem_hold_a: assert property (elem_valid && !elem_ready |=>
    (elem_valid && $stable(elem_data)) || !stream_open) else $error("element not held");
  drop_data_a: assert property (elem_valid && elem_ready |=>
    !elem_valid && elem_data == '0) else $error("element kept");
  one_fetch_a: assert property (elem_valid |-> !mem_req)
    else $error("fetch while offered");
  real_subs_a: assert property (elem_valid && !elem_complex |->
    elem_sub0 == '0 && elem_sub1 == '0) else $error("subs on real");
  cplx_split_a: assert property (elem_valid && elem_complex && elem_size == 2'h3 |->
    {elem_sub1, elem_sub0} == elem_data) else $error("complex split wrong");
  data_mask_a: assert property (elem_valid && elem_size != 2'h3 |->
    (elem_data >> (8 << elem_size)) == '0) else $error("data too wide");
  fetch_size_a: assert property (mem_req |-> mem_size == elem_size)
    else $error("fetch size differs");
  cfg_fixed_a: assert property (stream_open && $past(stream_open) |->
    $stable({elem_complex, elem_size})) else $error("type changed while open");

  handoff_c: cover property (elem_valid && elem_ready);
  close_c: cover property (elem_valid && !elem_ready ##1 !stream_open);
  cplx_c: cover property (elem_valid && elem_complex);
endmodule // walker_monitor

bind stream_element_address_walker walker_monitor #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_mon (
  .mclk, .reset, .mem_req, .mem_addr, .mem_size, .mem_gnt, .elem_valid, .elem_ready,
  .elem_data, .elem_sub0, .elem_sub1, .elem_complex, .elem_size, .stream_open);

`default_nettype wire

// file: sim/mem_model.sv
// Memory partner: grants a fetch one cycle late, answers lat+1 cycles after the grant is taken.
// Assumes one outstanding fetch at a time.
`timescale 1ns/1ps
`default_nettype none

module mem_model (
  // Clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 reset,
  // Fetch port
  input  wire logic                                 mem_req,
  input  wire logic [31:0]                          mem_addr,
  input  wire logic [3:0]                           lat,
  output logic                                      mem_gnt,
  output logic                                      mem_rvalid,
  output logic      [stream_walker_pkg::DATA_W-1:0] mem_rdata
);
  import stream_walker_pkg::*;
  logic [31:0] addr_q;
  logic [4:0]  wait_q;

  // Grant a cycle late
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_gnt <= 1'b0;
    end else begin
      mem_gnt <= mem_req && !mem_gnt && wait_q == 5'h00;
    end
  end

  // Never written: every fetch of an address agrees
  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_q <= 5'h00;
      addr_q <= 32'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= '0;
    end else if (mem_req && mem_gnt) begin
      wait_q <= {1'b0, lat} + 5'h01;
      addr_q <= mem_addr;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_q == 5'h01) begin
      wait_q <= 5'h00;
      mem_rvalid <= 1'b1;
      mem_rdata <= {~addr_q, addr_q};
    end else begin
      if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_model

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the stream walker.
// Assumes mem_model as memory, the bench as core.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import stream_walker_pkg::*;
  logic        mclk, reset, avs_read, avs_write, avs_waitrequest;
  logic        mem_req, mem_gnt, mem_rvalid, elem_valid, elem_ready;
  logic        elem_complex, elem_float, elem_signed, stream_open;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, mem_addr, elem_sub0, elem_sub1;
  logic [63:0] mem_rdata, elem_data, rd;
  logic [1:0]  mem_size, elem_size;
  logic [3:0]  lat;
  int          n_errors, tests_run, esz;
  int          ic[6], st[6];
  int          exp_q[$];

  stream_element_address_walker i_dut (
    .mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mem_req, .mem_addr,
    .mem_size, .mem_gnt, .mem_rvalid, .mem_rdata, .elem_valid, .elem_ready,
    .elem_data, .elem_sub0, .elem_sub1, .elem_complex, .elem_float,
    .elem_signed, .elem_size, .stream_open);
  mem_model i_mem (.mclk, .reset, .mem_req, .mem_addr, .lat, .mem_gnt, .mem_rvalid,
    .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = {32'h0, avs_readdata};
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      final_report();
    end
    @(posedge mclk);
  endtask

  // Reference walk
  function automatic void walk(input int lvl, ref int p);
    int s;
    for (int i = 0; i < ic[lvl]; i++) begin
      s = p;
      if (lvl == 0) begin
        exp_q.push_back(p);
        p = p + esz;
      end else begin
        walk(lvl - 1, p);
        p = s + st[lvl] * esz;
      end
    end
  endfunction

  task automatic setup(input logic [31:0] b, input logic [4:0] cfg);
    int p;
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h08, b);
    bus(1'b1, 8'h0C, {27'h0, cfg});
    for (int l = 0; l < 6; l++) begin
      bus(1'b1, 8'(16 + 4 * l), 32'(ic[l]));
      if (l > 0) bus(1'b1, 8'(36 + 4 * l), 32'(st[l]));
    end
    esz = 1 << cfg[1:0];
    exp_q = {};
    p = b;
    walk(5, p);
  endtask

  // Core: takes n_take elements
  task automatic consume(input int n_take, input logic stall);
    int n, got;
    logic [31:0] a;
    logic [63:0] e;
    got = 0;
    for (n = 0; n < 3000 && got < n_take; n++) begin
      elem_ready <= !(stall && n[1]);
      @(posedge mclk);
      if (elem_valid === 1'b1 && elem_ready === 1'b1) begin
        a = exp_q.pop_front();
        e = {~a, a};
        if (esz < 8) e = e & ((64'h1 << (8 * esz)) - 64'h1);
        check(elem_data, e, "elem_data");
        if (elem_complex === 1'b1) check({32'h0, elem_sub1}, {32'h0, ~a}, "sub1");
        got++;
      end
    end
    elem_ready <= 1'b0;
    if (got < n_take) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic reg_reset;
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 64'h0, "unmapped");
    for (int l = 1; l < 6; l++) begin
      bus(1'b0, 8'(12 + 4 * l), 32'h0);
      check(rd, 64'h1, "count");
      bus(1'b0, 8'(36 + 4 * l), 32'h0);
      check(rd, 64'h0, "stride");
    end
  endtask

  task automatic walk_real;
    ic = '{3, 2, 2, 2, 1, 1};
    st = '{0, 0, 8, -3, 0, 0};
    setup(32'h0000_1000, 5'h02);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h08, 32'h0000_2000);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 64'h0000_1000, "base");
    consume(24, 1'b1);
    bus(1'b0, 8'h04, 32'h0);
    check(rd & 64'h2, 64'h2, "done");
    bus(1'b0, 8'h3C, 32'h0);
    check(rd, 64'h0000_0018, "delivered");
  endtask

  task automatic walk_complex;
    ic = '{2, 1, 1, 1, 1, 2};
    st = '{0, 0, 0, 0, 0, -4};
    lat <= 4'h6;
    setup(32'h0000_0040, 5'h0F);
    bus(1'b1, 8'h00, 32'h1);
    check({62'h0, elem_float, elem_signed}, 64'h2, "type");
    consume(4, 1'b0);
  endtask

  task automatic close_mid;
    int bad;
    setup(32'h0000_0100, 5'h0F);
    bus(1'b1, 8'h00, 32'h1);
    consume(1, 1'b0);
    bus(1'b1, 8'h00, 32'h2);
    bad = 0;
    repeat (20) begin
      @(posedge mclk);
      if ({stream_open, elem_valid, mem_req} !== 3'b000) bad++;
    end
    check(64'(bad), 64'h0, "idle after close");
  endtask

  task automatic bad_open;
    ic = '{1, 1, 1, 1, 1, 1};
    setup(32'h0, 5'h04);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    check(rd & 64'h5, 64'h4, "status");
  endtask

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    elem_ready = 1'b0;
    lat = 4'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    reg_reset();
    walk_real();
    walk_complex();
    close_mid();
    bad_open();
    final_report();
  end
endmodule // tb

`default_nettype wire
